/* dv/mpfs_phy_model.sv */
// Purpose: External transceiver seen from the shared pins
// Assumes: Active only while the strap selects external mode
// Notes:   Mgmt data only driven while the device lets go of it
`timescale 1ns/1ps
module mpfs_phy_model (
   input  wire logic       en,
   input  wire logic       crs_set,
   input  wire logic       col_set,
   input  wire logic       rd_bit,
   input  wire logic [4:0] dev_oe,
   output logic [4:0]      drv,
   output logic [4:0]      drv_oe
);
   always_comb begin
      drv       = 5'h00;
      drv_oe    = 5'h00;
      drv[0]    = crs_set;
      drv_oe[0] = en;
      drv[1]    = col_set;
      drv_oe[1] = en;
      drv[2]    = rd_bit;
      drv_oe[2] = en & !dev_oe[2];
   end
endmodule

/* dv/mpfs_props.sv */
// Purpose: Port checks for the shared pin selector
// Assumes: Strap held steady from reset release
// Notes:   Mode is tracked here, the checker sees ports only
`timescale 1ns/1ps
module mpfs_props (
   input wire logic                    clk,
   input wire logic                    rst_n,
   input wire logic                    ext_mode_strap,
   input wire logic [4:0]              pin_i,
   input wire mpfs_pkg::mpfs_pins_t    pin_q,
   input wire mpfs_pkg::mpfs_mac_drv_t mac_drv,
   input wire mpfs_pkg::mpfs_mac_rcv_t mac_rcv_q,
   input wire logic                    power_event_mode_select_q,
   input wire logic                    irq_q
);
   logic [2:0] cnt_q;
   logic       known_q;
   logic       ext_q;
   logic       ok_q;
   logic       ex;
   logic       im;
   ////////////////////////////////////////////////////////////////////////////////
   // Strap taken at 4th edge; pins follow one edge later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q   <= 3'h0;
         known_q <= 1'b0;
         ext_q   <= 1'b0;
         ok_q    <= 1'b0;
      end else begin
         if (cnt_q != 3'h4) cnt_q <= cnt_q + 3'h1;
         if (cnt_q == 3'h3) begin
            known_q <= 1'b1;
            ext_q   <= ext_mode_strap;
         end
         ok_q <= known_q;
      end
   end
   assign ex = ok_q & ext_q;
   assign im = ok_q & !ext_q;
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_quiet; !ok_q |-> pin_q.oe == 5'h00; endproperty
   property p_crs;
      ex |-> !pin_q.oe[0] && mac_rcv_q.crs == $past(pin_i[0], 3);
   endproperty
   property p_col;
      ex |-> !pin_q.oe[1] && mac_rcv_q.col == $past(pin_i[1], 3);
   endproperty
   property p_mdio;
      ex |-> pin_q.oe[2] == $past(mac_drv.mdio_oe) && mac_rcv_q.mdio_i == $past(pin_i[2], 3)
         && (!pin_q.oe[2] || pin_q.o[2] == $past(mac_drv.mdio_o));
   endproperty
   property p_mdc; ex |-> pin_q.oe[3] && pin_q.o[3] == $past(mac_drv.mdc); endproperty
   property p_txd3; ex |-> pin_q.oe[4] && pin_q.o[4] == $past(mac_drv.txd3); endproperty
   property p_no_mac; im |-> mac_rcv_q == 3'h0; endproperty
   property p_no_pse; ex |-> !power_event_mode_select_q; endproperty
   a_quiet: assert property (p_quiet) else $error("pin driven before mode known");
   a_crs: assert property (p_crs) else $error("carrier path wrong");
   a_col: assert property (p_col) else $error("collision path wrong");
   a_mdio: assert property (p_mdio) else $error("mgmt data path wrong");
   a_mdc: assert property (p_mdc) else $error("mgmt clock path wrong");
   a_txd3: assert property (p_txd3) else $error("tx data 3 path wrong");
   a_no_mac: assert property (p_no_mac) else $error("mac inputs live in internal mode");
   a_no_pse: assert property (p_no_pse) else $error("power mode select in ext mode");
   c_ext: cover property (ex && mac_rcv_q.col);
   c_pse: cover property (power_event_mode_select_q);
   c_irq: cover property ($rose(irq_q));
endmodule

bind mpfs_top mpfs_props u_props (
   .clk                       (clk),
   .rst_n                     (rst_n),
   .ext_mode_strap            (ext_mode_strap),
   .pin_i                     (pin_i),
   .pin_q                     (pin_q),
   .mac_drv                   (mac_drv),
   .mac_rcv_q                 (mac_rcv_q),
   .power_event_mode_select_q (power_event_mode_select_q),
   .irq_q                     (irq_q)
);

/* dv/mpfs_top_tb.sv */
// Purpose: Self-checking bench for the shared pin selector
// Assumes: Pads pulled high unless someone drives them
// Notes:   Each mode needs its own reset, the strap is fixed
`timescale 1ns/1ps
module mpfs_top_tb;
   logic                    clk = 1'b0;
   logic                    rst_n = 1'b0;
   logic                    strap = 1'b1;
   logic                    pme = 1'b0;
   logic                    crs_set = 1'b0;
   logic                    col_set = 1'b0;
   logic                    rd_bit = 1'b0;
   logic [4:0]              pad = 5'h1f;
   logic [4:0]              mii = 5'h00;
   logic [4:0]              pin_i;
   logic [4:0]              phy_drv;
   logic [4:0]              phy_oe;
   mpfs_pkg::mpfs_axi_req_t req = '0;
   mpfs_pkg::mpfs_axi_rsp_t rsp;
   mpfs_pkg::mpfs_pins_t    pq;
   mpfs_pkg::mpfs_mac_drv_t mac = '0;
   mpfs_pkg::mpfs_mac_rcv_t rcv;
   logic                    pse;
   logic                    irq;
   int                      num_errors = 0;
   int                      n_checks = 0;
   always #4 clk = ~clk;
   // Wire level from every party's enable
   always_comb for (int k = 0; k < 5; k++)
      pin_i[k] = pq.oe[k] ? pq.o[k] : (phy_oe[k] ? phy_drv[k] : pad[k]);
   mpfs_top dut (.clk(clk), .rst_n(rst_n), .ext_mode_strap(strap), .axi_req(req),
      .axi_rsp(rsp), .pin_i(pin_i), .pin_q(pq), .mii_int(mii), .mac_drv(mac),
      .mac_rcv_q(rcv), .pme_signal(pme), .power_event_mode_select_q(pse), .irq_q(irq));
   mpfs_phy_model phy (.en(strap), .crs_set(crs_set), .col_set(col_set), .rd_bit(rd_bit),
      .dev_oe(pq.oe), .drv(phy_drv), .drv_oe(phy_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tmo;
      num_errors++;
      $display("mismatch at %0t: bus wait ran out", $time);
      stop_test();
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw;
      logic w;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (aw && rsp.awready) begin
            aw = 1'b0;
            req.awvalid <= 1'b0;
         end
         if (w && rsp.wready) begin
            w = 1'b0;
            req.wvalid <= 1'b0;
         end
         if (rsp.bvalid) begin
            req.bready <= 1'b0;
            chk(32'(rsp.bresp), 32'(er));
            return;
         end
      end
      tmo();
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic pend;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      pend = 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (pend && rsp.arready) begin
            pend = 1'b0;
            req.arvalid <= 1'b0;
         end else if (!pend && rsp.rvalid) begin
            req.rready <= 1'b0;
            chk(rsp.rdata, e);
            chk(32'(rsp.rresp), 32'(er));
            return;
         end
      end
      tmo();
   endtask
   task reset(input logic s);
      rst_n <= 1'b0;
      strap <= s;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_ext;
      reset(1'b1);
      rd(mpfs_pkg::A_MODE, 32'h5, 2'h0);
      wr(8'h40, 32'h1, mpfs_pkg::RESP_SLVERR);
      rd(8'h40, 32'h0, mpfs_pkg::RESP_SLVERR);
      wr(mpfs_pkg::A_IRQ_MASK, 32'h6, 2'h0);
      wr(mpfs_pkg::A_GP_DIR, 32'hff, 2'h0);
      crs_set <= 1'b1;
      col_set <= 1'b1;
      repeat (5) @(posedge clk);
      chk(32'(rcv.crs), 32'h1);
      chk(32'(rcv.col), 32'h1);
      chk(32'(pq.oe[1:0]), 32'h0);
      chk(32'(irq), 32'h1);
      rd(mpfs_pkg::A_IRQ_STAT, 32'h6, 2'h0);
      wr(mpfs_pkg::A_IRQ_STAT, 32'h6, 2'h0);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      mac.mdc <= 1'b1;
      mac.txd3 <= 1'b1;
      rd_bit <= 1'b1;
      repeat (5) @(posedge clk);
      chk(32'(pq.o[3] & pq.oe[3]), 32'h1);
      chk(32'(pq.o[4] & pq.oe[4]), 32'h1);
      chk(32'(rcv.mdio_i), 32'h1);
      mac.mdio_oe <= 1'b1;
      mac.mdio_o <= 1'b1;
      repeat (2) @(posedge clk);
      chk(32'(pq.o[2] & pq.oe[2]), 32'h1);
   endtask
   task t_int;
      reset(1'b0);
      rd(mpfs_pkg::A_MODE, 32'h4, 2'h0);
      wr(mpfs_pkg::A_HWCFG, 32'h1, 2'h0);
      mii <= 5'h15;
      repeat (3) @(posedge clk);
      chk(32'(pq), 32'h2bf);
      wr(mpfs_pkg::A_HWCFG, 32'h0, 2'h0);
      wr(mpfs_pkg::A_GP_DIR, 32'hff, 2'h0);
      wr(mpfs_pkg::A_GP_OD, 32'h1, 2'h0);
      wr(mpfs_pkg::A_GP_OUT, 32'h5, 2'h0);
      repeat (5) @(posedge clk);
      chk(32'(pq), 32'h11d);
      rd(mpfs_pkg::A_GP_DIR, 32'h8f, 2'h0);
      rd(mpfs_pkg::A_GP_IN, 32'h5, 2'h0);
   endtask
   task t_pme;
      wr(mpfs_pkg::A_HWCFG, 32'h2, 2'h0);
      wr(mpfs_pkg::A_GP_DIR, 32'h1, 2'h0);
      wr(mpfs_pkg::A_GP_OD, 32'h0, 2'h0);
      pme <= 1'b1;
      repeat (5) @(posedge clk);
      chk(32'(pse), 32'h1);
      chk(32'(pq.o[1] & pq.oe[1]), 32'h1);
      rd(mpfs_pkg::A_MODE, 32'h6, 2'h0);
      pme <= 1'b0;
      pad[2] <= 1'b0;
      repeat (5) @(posedge clk);
      chk(32'({pse, pq.o[1]}), 32'h0);
   endtask
   task t_link;
      pad[4] <= 1'b0;
      wr(mpfs_pkg::A_HWCFG, 32'h4, 2'h0);
      wr(mpfs_pkg::A_GP_DIR, 32'h0, 2'h0);
      wr(mpfs_pkg::A_IRQ_MASK, 32'h0, 2'h0);
      pad[4] <= 1'b1;
      repeat (6) @(posedge clk);
      chk(32'(irq), 32'h0);
      rd(mpfs_pkg::A_IRQ_STAT, 32'h1, 2'h0);
      wr(mpfs_pkg::A_IRQ_MASK, 32'h1, 2'h0);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h1);
      wr(mpfs_pkg::A_IRQ_STAT, 32'h1, 2'h0);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
   endtask
   initial begin
      t_ext();
      t_int();
      t_pme();
      t_link();
      stop_test();
   end
endmodule

/* hw/mpfs_top.sv */
// Purpose: Function select for five shared interface / general purpose pins
// Assumes: Mode strap and pins are asynchronous; MAC and internal signals on clk
// Notes:   Registers over AXI4-Lite; one level interrupt from sticky events
`timescale 1ns/1ps

module mpfs_top (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   ext_mode_strap,
   input  wire mpfs_pkg::mpfs_axi_req_t axi_req,
   output mpfs_pkg::mpfs_axi_rsp_t      axi_rsp,
   input  wire logic [4:0]              pin_i,
   output mpfs_pkg::mpfs_pins_t         pin_q,
   input  wire logic [4:0]              mii_int,
   input  wire mpfs_pkg::mpfs_mac_drv_t mac_drv,
   output mpfs_pkg::mpfs_mac_rcv_t      mac_rcv_q,
   input  wire logic                   pme_signal,
   output logic                        power_event_mode_select_q,
   output logic                        irq_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [4:0] gp_to_pin(input logic [7:0] r);
      logic [4:0] v;
      v = '0;
      for (int i = 0; i < 5; i++) begin
         v[i] = r[mpfs_pkg::GP_OF_PIN[i]];
      end
      return v;
   endfunction

   function automatic logic [7:0] pin_to_gp(input logic [4:0] p);
      logic [7:0] v;
      v = '0;
      for (int i = 0; i < 5; i++) begin
         v[mpfs_pkg::GP_OF_PIN[i]] = p[i];
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   logic [4:0] pin_s3_q;
   logic       strap_s1_q;
   logic       strap_s2_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q   <= 5'h00;
         pin_s2_q   <= 5'h00;
         pin_s3_q   <= 5'h00;
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
      end else begin
         pin_s1_q   <= pin_i;
         pin_s2_q   <= pin_s1_q;
         pin_s3_q   <= pin_s2_q;
         strap_s1_q <= ext_mode_strap;
         strap_s2_q <= strap_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode capture, frozen until the next reset
   logic [1:0] cap_cnt_q;
   logic       known_q;
   logic       ext_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_cnt_q <= 2'h0;
         known_q   <= 1'b0;
         ext_q     <= 1'b0;
      end else if (!known_q) begin
         // Wait out the synchroniser so a stale reset value is never captured
         if (cap_cnt_q == mpfs_pkg::CAP_CYCLES) begin
            known_q <= 1'b1;
            ext_q   <= strap_s2_q;
         end else begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [2:0] hwcfg_q;
   logic [7:0] gp_dir_q;
   logic [7:0] gp_od_q;
   logic [7:0] gp_out_q;
   logic [2:0] stat_q;
   logic [2:0] mask_q;
   logic       aw_got_q;
   logic       w_got_q;
   logic [7:0] awaddr_q;
   logic [7:0] wdata_q;
   logic       wstrb0_q;
   logic       bvalid_q;
   logic [1:0] bresp_q;
   logic       rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic       aw_hs;
   logic       w_hs;
   logic       wr_go;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic       wr_en;
   logic       ar_hs;
   logic       wr_ok;
   assign axi_rsp.awready = !aw_got_q && !bvalid_q;
   assign axi_rsp.wready  = !w_got_q && !bvalid_q;
   assign axi_rsp.bvalid  = bvalid_q;
   assign axi_rsp.bresp   = bresp_q;
   assign axi_rsp.arready = !rvalid_q;
   assign axi_rsp.rvalid  = rvalid_q;
   assign axi_rsp.rdata   = rdata_q;
   assign axi_rsp.rresp   = rresp_q;
   assign aw_hs   = axi_req.awvalid && axi_rsp.awready;
   assign w_hs    = axi_req.wvalid && axi_rsp.wready;
   assign wr_go   = (aw_got_q || aw_hs) && (w_got_q || w_hs);
   assign wr_addr = aw_got_q ? awaddr_q : axi_req.awaddr;
   assign wr_data = w_got_q ? wdata_q : axi_req.wdata[7:0];
   assign wr_en   = wr_go && (w_got_q ? wstrb0_q : axi_req.wstrb[0]);
   assign ar_hs   = axi_req.arvalid && axi_rsp.arready;
   always_comb begin
      case (wr_addr)
         mpfs_pkg::A_HWCFG, mpfs_pkg::A_GP_DIR, mpfs_pkg::A_GP_OD,
         mpfs_pkg::A_GP_OUT, mpfs_pkg::A_GP_IN, mpfs_pkg::A_IRQ_STAT,
         mpfs_pkg::A_IRQ_MASK, mpfs_pkg::A_MODE: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // Write channel: address and data in either order, response after both
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 8'h00;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= mpfs_pkg::RESP_OKAY;
      end else begin
         if (aw_hs) begin
            awaddr_q <= axi_req.awaddr;
         end
         if (w_hs) begin
            wdata_q  <= axi_req.wdata[7:0];
            wstrb0_q <= axi_req.wstrb[0];
         end
         if (wr_go) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? mpfs_pkg::RESP_OKAY : mpfs_pkg::RESP_SLVERR;
         end else begin
            aw_got_q <= aw_got_q || aw_hs;
            w_got_q  <= w_got_q || w_hs;
            if (bvalid_q && axi_req.bready) begin
               bvalid_q <= 1'b0;
            end
         end
      end
   end

   // Software writable configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hwcfg_q  <= mpfs_pkg::HWCFG_RST;
         gp_dir_q <= mpfs_pkg::GP_RST;
         gp_od_q  <= mpfs_pkg::GP_RST;
         gp_out_q <= mpfs_pkg::GP_RST;
         mask_q   <= mpfs_pkg::MASK_RST;
      end else if (wr_en) begin
         case (wr_addr)
            mpfs_pkg::A_HWCFG:    hwcfg_q  <= wr_data[2:0];
            mpfs_pkg::A_GP_DIR:   gp_dir_q <= pin_to_gp(gp_to_pin(wr_data));
            mpfs_pkg::A_GP_OD:    gp_od_q  <= pin_to_gp(gp_to_pin(wr_data));
            mpfs_pkg::A_GP_OUT:   gp_out_q <= pin_to_gp(gp_to_pin(wr_data));
            mpfs_pkg::A_IRQ_MASK: mask_q   <= wr_data[2:0];
            default: ;
         endcase
      end
   end

   // Read channel: one cycle to data, held until taken
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= mpfs_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rresp_q  <= mpfs_pkg::RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
         case (axi_req.araddr)
            mpfs_pkg::A_HWCFG:    rdata_q[2:0] <= hwcfg_q;
            mpfs_pkg::A_GP_DIR:   rdata_q[7:0] <= gp_dir_q;
            mpfs_pkg::A_GP_OD:    rdata_q[7:0] <= gp_od_q;
            mpfs_pkg::A_GP_OUT:   rdata_q[7:0] <= gp_out_q;
            mpfs_pkg::A_GP_IN:    rdata_q[7:0] <= pin_to_gp(pin_s2_q);
            mpfs_pkg::A_IRQ_STAT: rdata_q[2:0] <= stat_q;
            mpfs_pkg::A_IRQ_MASK: rdata_q[2:0] <= mask_q;
            mpfs_pkg::A_MODE:     rdata_q[2:0] <= {known_q, power_event_mode_select_q, ext_q};
            default:              rresp_q      <= mpfs_pkg::RESP_SLVERR;
         endcase
      end else if (rvalid_q && axi_req.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Events and interrupt
   logic       int_mode;
   logic       pme_on;
   logic [2:0] ev;
   assign int_mode = known_q && !ext_q;
   assign pme_on   = int_mode && hwcfg_q[mpfs_pkg::HWCFG_PME];
   always_comb begin
      ev = 3'h0;
      // Wake only counts while pin four (general purpose seven) is an input
      ev[mpfs_pkg::EV_LINK] = int_mode && hwcfg_q[mpfs_pkg::HWCFG_LWAKE]
         && !gp_dir_q[mpfs_pkg::GP_OF_PIN[mpfs_pkg::P_TXD3]]
         && pin_s2_q[mpfs_pkg::P_TXD3] && !pin_s3_q[mpfs_pkg::P_TXD3];
      ev[mpfs_pkg::EV_COL] = known_q && ext_q
         && pin_s2_q[mpfs_pkg::P_COL] && !pin_s3_q[mpfs_pkg::P_COL];
      ev[mpfs_pkg::EV_CRS] = known_q && ext_q
         && pin_s2_q[mpfs_pkg::P_CRS] && !pin_s3_q[mpfs_pkg::P_CRS];
   end

   // Set beats a same-cycle write-one clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= 3'h0;
      end else if (wr_en && wr_addr == mpfs_pkg::A_IRQ_STAT) begin
         stat_q <= (stat_q & ~wr_data[2:0]) | ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin function select
   logic [4:0] g_dir;
   logic [4:0] g_od;
   logic [4:0] g_out;
   mpfs_pkg::mpfs_pins_t pin_d;
   assign g_dir = gp_to_pin(gp_dir_q);
   assign g_od  = gp_to_pin(gp_od_q);
   assign g_out = gp_to_pin(gp_out_q);
   // Priority: undecided mode, external, power event, visibility, general purpose
   always_comb begin
      pin_d = '0;
      for (int i = 0; i < 5; i++) begin
         logic dat;
         logic dir;
         dat = g_out[i];
         dir = g_dir[i];
         if (!known_q) begin
            // All pins float until the strap is captured
            pin_d.oe[i] = 1'b0;
         end else if (ext_q) begin
            if (i == mpfs_pkg::P_MDIO) begin
               pin_d.o[i]  = mac_drv.mdio_o;
               pin_d.oe[i] = mac_drv.mdio_oe;
            end else if (i == mpfs_pkg::P_MDC) begin
               pin_d.o[i]  = mac_drv.mdc;
               pin_d.oe[i] = 1'b1;
            end else if (i == mpfs_pkg::P_TXD3) begin
               pin_d.o[i]  = mac_drv.txd3;
               pin_d.oe[i] = 1'b1;
            end
         end else if (pme_on && i == mpfs_pkg::P_MDIO) begin
            pin_d.oe[i] = 1'b0;
         end else if (hwcfg_q[mpfs_pkg::HWCFG_VIS] && !(pme_on && i == mpfs_pkg::P_COL)) begin
            pin_d.o[i]  = mii_int[i];
            pin_d.oe[i] = 1'b1;
         end else begin
            if (pme_on && i == mpfs_pkg::P_COL) begin
               dat = pme_signal;
               dir = 1'b1;
            end
            // Open drain only ever pulls low
            pin_d.o[i]  = g_od[i] ? 1'b0 : dat;
            pin_d.oe[i] = g_od[i] ? (dir && !dat) : dir;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_q <= '0;
      end else begin
         pin_q <= pin_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Inputs toward the MAC and power-event logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mac_rcv_q                 <= '0;
         power_event_mode_select_q <= 1'b0;
      end else begin
         mac_rcv_q.crs    <= known_q && ext_q && pin_s2_q[mpfs_pkg::P_CRS];
         mac_rcv_q.col    <= known_q && ext_q && pin_s2_q[mpfs_pkg::P_COL];
         mac_rcv_q.mdio_i <= known_q && ext_q && pin_s2_q[mpfs_pkg::P_MDIO];
         power_event_mode_select_q <= pme_on && pin_s2_q[mpfs_pkg::P_MDIO];
      end
   end

endmodule

/* inc/mpfs_pkg.sv */
// Purpose: Constants and carriers for the shared pin function selector
// Assumes: 125 MHz core clock, AXI4-Lite register access, 8-bit byte address
// Notes:   Pin order is carrier sense, collision, mgmt data, mgmt clock, tx data 3
package mpfs_pkg;

   localparam int unsigned NPIN = 5;
   localparam int unsigned NEV  = 3;

   // Register byte addresses
   localparam logic [7:0] A_HWCFG    = 8'h00;
   localparam logic [7:0] A_GP_DIR   = 8'h04;
   localparam logic [7:0] A_GP_OD    = 8'h08;
   localparam logic [7:0] A_GP_OUT   = 8'h0C;
   localparam logic [7:0] A_GP_IN    = 8'h10;
   localparam logic [7:0] A_IRQ_STAT = 8'h14;
   localparam logic [7:0] A_IRQ_MASK = 8'h18;
   localparam logic [7:0] A_MODE     = 8'h1C;

   // Field positions
   localparam int unsigned HWCFG_VIS   = 0;
   localparam int unsigned HWCFG_PME   = 1;
   localparam int unsigned HWCFG_LWAKE = 2;
   localparam int unsigned EV_LINK     = 0;
   localparam int unsigned EV_COL      = 1;
   localparam int unsigned EV_CRS      = 2;
   localparam int unsigned MODE_EXT    = 0;
   localparam int unsigned MODE_PSEL   = 1;
   localparam int unsigned MODE_KNOWN  = 2;

   // Reset values
   localparam logic [2:0] HWCFG_RST = 3'h0;
   localparam logic [7:0] GP_RST    = 8'h00;
   localparam logic [2:0] MASK_RST  = 3'h0;

   // Cycles after reset release before the mode strap is trusted
   localparam logic [1:0] CAP_CYCLES = 2'h3;

   // Pin indices and the general purpose number each pin carries
   localparam int unsigned P_CRS  = 0;
   localparam int unsigned P_COL  = 1;
   localparam int unsigned P_MDIO = 2;
   localparam int unsigned P_MDC  = 3;
   localparam int unsigned P_TXD3 = 4;
   localparam logic [2:0] GP_OF_PIN [NPIN] = '{3'h3, 3'h0, 3'h1, 3'h2, 3'h7};

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } mpfs_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } mpfs_axi_rsp_t;

   typedef struct packed {
      logic [NPIN-1:0] o;
      logic [NPIN-1:0] oe;
   } mpfs_pins_t;

   typedef struct packed {
      logic mdio_o;
      logic mdio_oe;
      logic mdc;
      logic txd3;
   } mpfs_mac_drv_t;

   typedef struct packed {
      logic crs;
      logic col;
      logic mdio_i;
   } mpfs_mac_rcv_t;

endpackage
